// >>> design/mrx_exec.sv
// executor for nop, option load, software reset and returns
// Operation
// - option load copies w into option register
// - reset instruction triggers full device reset
// - reset instruction clears reset flag bit
// - interrupt return pops stack into pc
// - interrupt return sets global irq enable
// - interrupt return takes two instruction cycles
// - subroutine return pops stack, two cycles
`include "mrx_defines.svh"
module mrx_exec (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// instruction in
	input wire logic instr_valid,
	input wire logic [13:0] instr_word,
	input wire logic [7:0] w_reg,
	input wire logic [14:0] stack_top,
	// core outputs
	output logic [14:0] pc_r,
	output logic [7:0] option_reg_r,
	output logic global_irq_enable_r,
	output logic stack_pop_r,
	output logic sw_reset_req_r,
	output logic reset_instr_flag_n_r,
	output logic busy_r,
	output logic done_r
);
	mrx_dec_if dif ();
	mrx_pkg::mrx_state_e state_r;
	mrx_pkg::mrx_state_e state_nxt;
	logic take;
	logic is_opt;
	logic is_rst;
	logic is_ret;
	logic is_retirq;
	logic is_simple;
	logic is_nop;
	logic [14:0] pc_nxt;
	logic [7:0] option_nxt;
	logic irq_en_nxt;
	logic done_nxt;

	assign dif.word = instr_word;
	mrx_decode u_mrx_decode (.d(dif));

	// second cycle of a return is a flush cycle, no new fetch accepted
	assign take = instr_valid && (state_r == mrx_pkg::MRX_S_EXEC);
	assign is_opt = take && (dif.kind == mrx_pkg::MRX_K_OPTION);
	assign is_rst = take && (dif.kind == mrx_pkg::MRX_K_RESET);
	assign is_retirq = take && (dif.kind == mrx_pkg::MRX_K_RETIRQ);
	assign is_ret = is_retirq || (take && (dif.kind == mrx_pkg::MRX_K_RETURN));
	assign is_nop = take && (dif.kind == mrx_pkg::MRX_K_NOP);
	// any other accepted word still advances pc; the rest of the core owns its effect
	assign is_simple = take && !is_ret && !is_rst;
	assign state_nxt = is_ret ? mrx_pkg::MRX_S_FLUSH : mrx_pkg::MRX_S_EXEC;

	// next values
	assign pc_nxt = is_ret ? stack_top : (is_simple ? pc_r + 15'h0001 : pc_r);
	assign option_nxt = is_opt ? w_reg : option_reg_r;
	assign irq_en_nxt = is_retirq || global_irq_enable_r;
	assign done_nxt = is_simple || (state_r == mrx_pkg::MRX_S_FLUSH);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_r <= mrx_pkg::MRX_S_EXEC;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pc_r <= `MRX_PC_RST;
		end else begin
			pc_r <= pc_nxt;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			option_reg_r <= `MRX_OPTION_RST;
		end else begin
			option_reg_r <= option_nxt;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			global_irq_enable_r <= 1'b0;
		end else begin
			global_irq_enable_r <= irq_en_nxt;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			stack_pop_r <= 1'b0;
			sw_reset_req_r <= 1'b0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			stack_pop_r <= is_ret;
			sw_reset_req_r <= is_rst;
			busy_r <= is_ret;
			done_r <= done_nxt;
		end
	end

	// flag lives outside the device reset so the cause survives; cleared by the instruction
	// powers up unknown, and nothing here ever sets it back to 1; only the instruction writes it
	always_ff @(posedge clk_sys) begin
		if (is_rst) begin
			reset_instr_flag_n_r <= 1'b0;
		end
	end

	property p_opt_load;
		@(posedge clk_sys) disable iff (!nrst) is_opt |=> option_reg_r == $past(w_reg);
	endproperty
	a_opt_load: assert property (p_opt_load) else $error("option load wrong");

	property p_rst_req;
		@(posedge clk_sys) disable iff (!nrst) is_rst |=> sw_reset_req_r && !done_r;
	endproperty
	a_rst_req: assert property (p_rst_req) else $error("reset request missing");

	property p_rst_flag;
		@(posedge clk_sys) disable iff (!nrst) is_rst |=> !reset_instr_flag_n_r;
	endproperty
	a_rst_flag: assert property (p_rst_flag) else $error("reset flag not cleared");

	property p_ret_pc;
		@(posedge clk_sys) disable iff (!nrst) is_ret |=> stack_pop_r && pc_r == $past(stack_top);
	endproperty
	a_ret_pc: assert property (p_ret_pc) else $error("return pc wrong");

	property p_irq_en;
		@(posedge clk_sys) disable iff (!nrst) is_retirq |=> global_irq_enable_r;
	endproperty
	a_irq_en: assert property (p_irq_en) else $error("irq enable not set");

	sequence s_ret_two;
		busy_r && !done_r ##1 done_r && !busy_r;
	endsequence
	property p_ret_two;
		@(posedge clk_sys) disable iff (!nrst) is_ret |=> s_ret_two;
	endproperty
	a_ret_two: assert property (p_ret_two) else $error("return not two cycles");

	sequence s_flush_quiet;
		!take ##1 ($stable(pc_r) && $stable(option_reg_r));
	endsequence
	property p_ret_block;
		@(posedge clk_sys) disable iff (!nrst) is_ret |=> s_flush_quiet;
	endproperty
	a_ret_block: assert property (p_ret_block) else $error("fetch during flush");

	property p_nop;
		@(posedge clk_sys) disable iff (!nrst)
			take && dif.kind == mrx_pkg::MRX_K_NOP |=> pc_r == $past(pc_r) + 15'h0001
			&& $stable(option_reg_r) && $stable(global_irq_enable_r);
	endproperty
	a_nop: assert property (p_nop) else $error("nop changed state");

	property p_opt_one;
		@(posedge clk_sys) disable iff (!nrst) is_opt |=> done_r && !busy_r && pc_r == $past(pc_r) + 15'h0001;
	endproperty
	a_opt_one: assert property (p_opt_one) else $error("option load not one cycle");

	property p_opt_side;
		@(posedge clk_sys) disable iff (!nrst)
			is_opt |=> $stable(global_irq_enable_r) && !stack_pop_r && !sw_reset_req_r;
	endproperty
	a_opt_side: assert property (p_opt_side) else $error("option load touched other state");

	property p_rst_src;
		@(posedge clk_sys) disable iff (!nrst) sw_reset_req_r |-> $past(is_rst);
	endproperty
	a_rst_src: assert property (p_rst_src) else $error("reset request without instruction");

	property p_rst_keep;
		@(posedge clk_sys) disable iff (!nrst)
			is_rst |=> $stable(pc_r) && $stable(option_reg_r) && $stable(global_irq_enable_r);
	endproperty
	a_rst_keep: assert property (p_rst_keep) else $error("reset instruction changed state");

	// checked through the device reset as well, the cause must survive it
	property p_flag_keep;
		@(posedge clk_sys) reset_instr_flag_n_r == 1'b0 |=> reset_instr_flag_n_r == 1'b0;
	endproperty
	a_flag_keep: assert property (p_flag_keep) else $error("reset flag lost");

	sequence s_pop_once;
		stack_pop_r ##1 !stack_pop_r;
	endsequence
	property p_pop_once;
		@(posedge clk_sys) disable iff (!nrst) is_ret |=> s_pop_once;
	endproperty
	a_pop_once: assert property (p_pop_once) else $error("stack popped more than once");

	property p_irq_src;
		@(posedge clk_sys) disable iff (!nrst) $rose(global_irq_enable_r) |-> $past(is_retirq);
	endproperty
	a_irq_src: assert property (p_irq_src) else $error("irq enable set without return");

	property p_busy_pop;
		@(posedge clk_sys) disable iff (!nrst) busy_r |-> stack_pop_r && !done_r;
	endproperty
	a_busy_pop: assert property (p_busy_pop) else $error("busy without pop");

	property p_flush_done;
		@(posedge clk_sys) disable iff (!nrst)
			state_r == mrx_pkg::MRX_S_FLUSH |=> done_r && !busy_r && !stack_pop_r;
	endproperty
	a_flush_done: assert property (p_flush_done) else $error("flush cycle did not finish");

	property p_ret_side;
		@(posedge clk_sys) disable iff (!nrst)
			is_ret && !is_retirq |=> $stable(global_irq_enable_r) && $stable(option_reg_r) && !sw_reset_req_r;
	endproperty
	a_ret_side: assert property (p_ret_side) else $error("subroutine return touched other state");

	property p_nop_quiet;
		@(posedge clk_sys) disable iff (!nrst)
			is_nop |=> done_r && !busy_r && !stack_pop_r && !sw_reset_req_r;
	endproperty
	a_nop_quiet: assert property (p_nop_quiet) else $error("nop raised a side effect");
endmodule // mrx_exec

// >>> design/mrx_defines.svh
// constants for the misc and return instruction executor
`ifndef MRX_DEFINES_SVH
`define MRX_DEFINES_SVH
`define MRX_OP_NOP 14'h0000
`define MRX_OP_OPTION 14'h0062
`define MRX_OP_RESET 14'h0001
`define MRX_OP_RETIRQ 14'h0009
`define MRX_OP_RETURN 14'h0008
`define MRX_IRQ_EN_BIT 7
`define MRX_OPTION_RST 8'hFF
`define MRX_PC_RST 15'h0000
`define MRX_RET_CYCLES 2
`define MRX_ONE_CYCLES 1
`endif

// >>> design/mrx_pkg.sv
// types for the misc and return instruction executor
package mrx_pkg;
	typedef enum logic [2:0] {
		MRX_K_OTHER = 3'h0,
		MRX_K_NOP = 3'h1,
		MRX_K_OPTION = 3'h2,
		MRX_K_RESET = 3'h3,
		MRX_K_RETIRQ = 3'h4,
		MRX_K_RETURN = 3'h5
	} mrx_kind_e;
	typedef enum logic [0:0] {
		MRX_S_EXEC = 1'b0,
		MRX_S_FLUSH = 1'b1
	} mrx_state_e;
endpackage

// >>> design/mrx_dec_if.sv
// decode bundle between decoder and executor
interface mrx_dec_if;
	logic [13:0] word;
	mrx_pkg::mrx_kind_e kind;
	modport dec (input word, output kind);
	modport exe (output word, input kind);
endinterface

// >>> design/mrx_decode.sv
// opcode decoder for the handled instruction group
`include "mrx_defines.svh"
module mrx_decode (
	// decode bundle
	mrx_dec_if.dec d
);
	function automatic mrx_pkg::mrx_kind_e mrx_classify(input logic [13:0] w);
		unique case (w)
			`MRX_OP_NOP: mrx_classify = mrx_pkg::MRX_K_NOP;
			`MRX_OP_OPTION: mrx_classify = mrx_pkg::MRX_K_OPTION;
			`MRX_OP_RESET: mrx_classify = mrx_pkg::MRX_K_RESET;
			`MRX_OP_RETIRQ: mrx_classify = mrx_pkg::MRX_K_RETIRQ;
			`MRX_OP_RETURN: mrx_classify = mrx_pkg::MRX_K_RETURN;
			default: mrx_classify = mrx_pkg::MRX_K_OTHER;
		endcase
	endfunction
	assign d.kind = mrx_classify(d.word);
endmodule // mrx_decode

// >>> verif/mrx_exec_tb.sv
// self-checking bench for the misc and return instruction executor
`include "mrx_defines.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("unexpected %s exp %0h got %0h", nm, e, g); end end
module mrx_exec_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic instr_valid = 1'b0;
	logic [13:0] instr_word = 14'h0000;
	logic [7:0] w_reg = 8'h00;
	logic [14:0] stack_top = 15'h0000;
	logic [14:0] pc_r;
	logic [7:0] option_reg_r;
	logic global_irq_enable_r, stack_pop_r, sw_reset_req_r, reset_instr_flag_n_r, busy_r, done_r;
	logic [14:0] pc0;
	int n_fail = 0;
	int samples_checked = 0;
	always #10 clk_sys = ~clk_sys;
	mrx_exec u_mrx_exec (.clk_sys(clk_sys), .nrst(nrst), .instr_valid(instr_valid), .instr_word(instr_word),
		.w_reg(w_reg), .stack_top(stack_top), .pc_r(pc_r), .option_reg_r(option_reg_r),
		.global_irq_enable_r(global_irq_enable_r), .stack_pop_r(stack_pop_r), .sw_reset_req_r(sw_reset_req_r),
		.reset_instr_flag_n_r(reset_instr_flag_n_r), .busy_r(busy_r), .done_r(done_r));
	// one-cycle request, returns just after the answer edge
	task automatic send(input logic [13:0] op);
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr_word <= op;
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		#1;
	endtask
	task automatic t_nop_opt();
		pc0 = pc_r;
		w_reg <= 8'h4F;
		send(`MRX_OP_NOP);
		`CHK("nop pc", pc0 + 15'h0001, pc_r)
		`CHK("nop option", 8'hFF, option_reg_r)
		`CHK("nop done", 1'b1, done_r)
		`CHK("nop irq enable", 1'b0, global_irq_enable_r)
		`CHK("nop pop", 1'b0, stack_pop_r)
		send(`MRX_OP_OPTION);
		`CHK("option", 8'h4F, option_reg_r)
		`CHK("option pc", pc0 + 15'h0002, pc_r)
		pc0 = pc_r;
		send(14'h3FFF);
		`CHK("unknown pc", pc0 + 15'h0001, pc_r)
		`CHK("unknown option", 8'h4F, option_reg_r)
	endtask
	task automatic t_reset();
		pc0 = pc_r;
		send(`MRX_OP_RESET);
		`CHK("reset req", 1'b1, sw_reset_req_r)
		`CHK("reset flag", 1'b0, reset_instr_flag_n_r)
		`CHK("reset pc", pc0, pc_r)
		@(posedge clk_sys);
		#1;
		`CHK("reset req pulse", 1'b0, sw_reset_req_r)
		// the request goes round the outer reset logic and comes back as nrst
		@(posedge clk_sys);
		nrst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		#1;
		`CHK("sw reset pc", `MRX_PC_RST, pc_r)
		`CHK("sw reset option", `MRX_OPTION_RST, option_reg_r)
		`CHK("sw reset irq enable", 1'b0, global_irq_enable_r)
		`CHK("sw reset flag kept", 1'b0, reset_instr_flag_n_r)
	endtask
	// second word lands in the flush cycle and must be dropped
	task automatic t_ret(input logic [13:0] op, input logic [14:0] top, input logic irq_exp);
		logic [7:0] opt0;
		opt0 = option_reg_r;
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr_word <= op;
		stack_top <= top;
		@(posedge clk_sys);
		instr_word <= `MRX_OP_OPTION;
		w_reg <= 8'h5A;
		#1;
		`CHK("ret pc", top, pc_r)
		`CHK("ret pop", 1'b1, stack_pop_r)
		`CHK("ret busy", 1'b1, busy_r)
		`CHK("ret irq enable", irq_exp, global_irq_enable_r)
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		#1;
		`CHK("ret done", 1'b1, done_r)
		`CHK("ret pop pulse", 1'b0, stack_pop_r)
		`CHK("ret busy pulse", 1'b0, busy_r)
		`CHK("flush option", opt0, option_reg_r)
		`CHK("flush pc", top, pc_r)
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		#1;
		`CHK("rst pc", 15'h0000, pc_r)
		`CHK("rst irq enable", 1'b0, global_irq_enable_r)
		t_nop_opt();
		// subroutine return first, so irq enable is still low and must stay low
		t_ret(`MRX_OP_RETURN, 15'h7FFF, 1'b0);
		t_ret(`MRX_OP_RETIRQ, 15'h1234, 1'b1);
		t_reset();
		print_verdict();
	end
	// run needs about thirty cycles; the limit allows a thousand
	initial begin
		#20000;
		n_fail++;
		print_verdict();
	end
endmodule // mrx_exec_tb
